// >>> design/rcr_pkg.sv
package rcr_pkg;

   // ---------------------------------------------------------------
   // register offsets (5-bit address space)
   // ---------------------------------------------------------------
   localparam logic [4:0] ADR_CHIP_STATUS_CONTROL   = 5'h00;
   localparam logic [4:0] ADR_PROTOCOL_SELECT       = 5'h01;
   localparam logic [4:0] ADR_TYPE_B_TX_OPTIONS     = 5'h02;
   localparam logic [4:0] ADR_TYPE_A_RATE_OPTIONS   = 5'h03;
   localparam logic [4:0] ADR_TX_PULSE_LENGTH       = 5'h06;
   localparam logic [4:0] ADR_RX_NO_RESPONSE_TIMEOUT = 5'h07;
   localparam logic [4:0] ADR_RX_WAIT_TIME          = 5'h08;
   localparam logic [4:0] ADR_MODULATOR_CLOCK_OUT   = 5'h09;
   localparam logic [4:0] ADR_RX_SPECIAL_SETTING    = 5'h0a;
   localparam logic [4:0] ADR_REGULATOR_IO_CONTROL  = 5'h0b;
   localparam logic [4:0] ADR_INTERRUPT_STATUS      = 5'h0c;
   localparam logic [4:0] ADR_COLLISION_AND_IRQ_MASK = 5'h0d;
   localparam logic [4:0] ADR_COLLISION_LOCATION    = 5'h0e;
   localparam logic [4:0] ADR_SIGNAL_STRENGTH_OSC   = 5'h0f;
   localparam logic [4:0] ADR_TEST_A                = 5'h1a;
   localparam logic [4:0] ADR_TEST_B                = 5'h1b;
   localparam logic [4:0] ADR_QUEUE_STATUS          = 5'h1c;
   localparam logic [4:0] ADR_TX_LENGTH_HIGH        = 5'h1d;
   localparam logic [4:0] ADR_TX_LENGTH_LOW         = 5'h1e;
   localparam logic [4:0] ADR_QUEUE_DATA_PORT       = 5'h1f;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_CHIP_STATUS_CONTROL = 8'h01;
   localparam logic [7:0] RST_PROTOCOL_SELECT     = 8'h02;
   localparam logic [7:0] RST_OTHER               = 8'h00;
   // registered front-end controls as decoded from the status reset value
   localparam logic [12:0] RST_CONTROL_OUTPUTS    = 13'h1026;

   // ---------------------------------------------------------------
   // chip status control field positions
   // ---------------------------------------------------------------
   localparam int BIT_STANDBY      = 7;
   localparam int BIT_RAW_FRONTEND = 6;
   localparam int BIT_TX_ENABLE    = 5;
   localparam int BIT_POWER_SEL    = 4;
   localparam int BIT_RX_INPUT_SEL = 3;
   localparam int BIT_AUTO_GAIN    = 2;
   localparam int BIT_FORCED_RX    = 1;
   localparam int BIT_SUPPLY_RANGE = 0;

   // protocol select: raw-mode type bit
   localparam int BIT_RAW_TYPE     = 6;

   // ---------------------------------------------------------------
   // access word layout
   // ---------------------------------------------------------------
   localparam int WORD_CMD_BIT   = 7;
   localparam int WORD_READ_BIT  = 6;
   localparam int WORD_CONT_BIT  = 5;
   localparam int WORD_ADR_MSB   = 4;

   // number of register slots in the address space
   localparam int NUM_SLOTS = 32;

   // ---------------------------------------------------------------
   // access sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      RCR_IDLE,
      RCR_WRITE_DATA,
      RCR_READ_DATA
   } rcr_state_type;

endpackage

// >>> design/rcr_bank_if.sv
`timescale 1ns/100ps
interface rcr_bank_if;
   logic       wr_en;
   logic [4:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport seq (output wr_en, output addr, output wdata, input rdata);
   modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface

// >>> design/rcr_reg_bank.sv
`timescale 1ns/100ps
module rcr_reg_bank (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // sequencer side
   rcr_bank_if.bank        bus,
   // read-only sources
   input  wire logic [7:0] irq_status_in,
   input  wire logic [7:0] collision_in,
   input  wire logic [7:0] rssi_in,
   input  wire logic [7:0] queue_status_in,
   input  wire logic [7:0] queue_data_in,
   // register contents
   output logic      [7:0] chip_status_control,
   output logic      [7:0] protocol_select
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [7:0] regs_r   [rcr_pkg::NUM_SLOTS];
   logic [7:0] regs_nxt [rcr_pkg::NUM_SLOTS];

   // writable slot decode
   function automatic logic writable(input logic [4:0] a);
      case (a)
         rcr_pkg::ADR_CHIP_STATUS_CONTROL, rcr_pkg::ADR_PROTOCOL_SELECT,
         rcr_pkg::ADR_TYPE_B_TX_OPTIONS, rcr_pkg::ADR_TYPE_A_RATE_OPTIONS,
         rcr_pkg::ADR_TX_PULSE_LENGTH, rcr_pkg::ADR_RX_NO_RESPONSE_TIMEOUT,
         rcr_pkg::ADR_RX_WAIT_TIME, rcr_pkg::ADR_MODULATOR_CLOCK_OUT,
         rcr_pkg::ADR_RX_SPECIAL_SETTING, rcr_pkg::ADR_REGULATOR_IO_CONTROL,
         rcr_pkg::ADR_COLLISION_AND_IRQ_MASK, rcr_pkg::ADR_TEST_A,
         rcr_pkg::ADR_TEST_B, rcr_pkg::ADR_TX_LENGTH_HIGH,
         rcr_pkg::ADR_TX_LENGTH_LOW: writable = 1'b1;
         default: writable = 1'b0;
      endcase
   endfunction

   // next values: read-only slots never take writes
   always_comb begin
      for (int i = 0; i < rcr_pkg::NUM_SLOTS; i++) begin
         regs_nxt[i] = regs_r[i];
      end
      if (bus.wr_en && writable(bus.addr)) begin
         regs_nxt[bus.addr] = bus.wdata;
      end
   end

   // register update with reset defaults
   always_ff @(posedge clk) begin
      for (int i = 0; i < rcr_pkg::NUM_SLOTS; i++) begin
         if (!rst_n) begin
            regs_r[i] <= rcr_pkg::RST_OTHER;
         end else begin
            regs_r[i] <= regs_nxt[i];
         end
      end
      if (!rst_n) begin
         regs_r[rcr_pkg::ADR_CHIP_STATUS_CONTROL] <= rcr_pkg::RST_CHIP_STATUS_CONTROL;
         regs_r[rcr_pkg::ADR_PROTOCOL_SELECT]     <= rcr_pkg::RST_PROTOCOL_SELECT;
      end
   end

   // read mux: read-only slots show live state
   always_comb begin
      case (bus.addr)
         rcr_pkg::ADR_INTERRUPT_STATUS:     bus.rdata = irq_status_in;
         rcr_pkg::ADR_COLLISION_LOCATION:   bus.rdata = collision_in;
         rcr_pkg::ADR_SIGNAL_STRENGTH_OSC:  bus.rdata = rssi_in;
         rcr_pkg::ADR_QUEUE_STATUS:         bus.rdata = queue_status_in;
         rcr_pkg::ADR_QUEUE_DATA_PORT:      bus.rdata = queue_data_in;
         default: bus.rdata = writable(bus.addr) ? regs_r[bus.addr] : 8'h00;
      endcase
   end

   assign chip_status_control = regs_r[rcr_pkg::ADR_CHIP_STATUS_CONTROL];
   assign protocol_select     = regs_r[rcr_pkg::ADR_PROTOCOL_SELECT];

endmodule

// >>> design/rcr_control.sv
`timescale 1ns/100ps
module rcr_control (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // host access port (one byte per strobe)
   input  wire logic       host_valid,
   input  wire logic [7:0] host_byte,
   input  wire logic       host_frame_end,
   output logic            host_rd_valid,
   output logic      [7:0] host_rd_data,
   // read-only sources
   input  wire logic [7:0] irq_status_in,
   input  wire logic [7:0] collision_in,
   input  wire logic [7:0] rssi_in,
   input  wire logic [7:0] queue_status_in,
   input  wire logic [7:0] queue_data_in,
   // front-end controls
   output logic            standby,
   output logic            regulators_on,
   output logic            host_clock_output_on,
   output logic            raw_frontend,
   output logic            raw_type,
   output logic            framer_enable,
   output logic            transmitter_on,
   output logic            transmit_oscillator_on,
   output logic            receiver_on,
   output logic            half_power,
   output logic            auxiliary_input_sel,
   output logic            auto_gain_on,
   output logic            supply_5v
);

   // ---------------------------------------------------------------
   // access sequencer
   // ---------------------------------------------------------------
   rcr_bank_if bank_bus ();

   rcr_pkg::rcr_state_type state_r;
   rcr_pkg::rcr_state_type state_nxt;
   logic [4:0] addr_r;
   logic [4:0] addr_nxt;
   logic       cont_r;
   logic       cont_nxt;
   logic       rd_valid_r;
   logic       rd_valid_nxt;
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;
   logic       wr_en;

   logic [7:0] csc;
   logic [7:0] psel;

   // decode access words, then data bytes
   always_comb begin
      state_nxt    = state_r;
      addr_nxt     = addr_r;
      cont_nxt     = cont_r;
      rd_valid_nxt = 1'b0;
      rd_data_nxt  = rd_data_r;
      wr_en        = 1'b0;
      case (state_r)
         rcr_pkg::RCR_IDLE: begin
            if (host_valid && !host_byte[rcr_pkg::WORD_CMD_BIT]) begin
               addr_nxt = host_byte[rcr_pkg::WORD_ADR_MSB:0];
               cont_nxt = host_byte[rcr_pkg::WORD_CONT_BIT];
               if (host_byte[rcr_pkg::WORD_READ_BIT]) begin
                  state_nxt = rcr_pkg::RCR_READ_DATA;
               end else begin
                  state_nxt = rcr_pkg::RCR_WRITE_DATA;
               end
            end
         end
         rcr_pkg::RCR_WRITE_DATA: begin
            if (host_valid) begin
               wr_en = 1'b1;
               if (cont_r) begin
                  addr_nxt = addr_r + 5'h01;
               end else begin
                  state_nxt = rcr_pkg::RCR_IDLE;
               end
            end
         end
         rcr_pkg::RCR_READ_DATA: begin
            if (host_valid) begin
               rd_valid_nxt = 1'b1;
               rd_data_nxt  = bank_bus.rdata;
               if (cont_r) begin
                  addr_nxt = addr_r + 5'h01;
               end else begin
                  state_nxt = rcr_pkg::RCR_IDLE;
               end
            end
         end
         default: state_nxt = rcr_pkg::RCR_IDLE;
      endcase
      if (host_frame_end) begin
         state_nxt = rcr_pkg::RCR_IDLE;
      end
   end

   // sequencer registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r    <= rcr_pkg::RCR_IDLE;
         addr_r     <= 5'h00;
         cont_r     <= 1'b0;
         rd_valid_r <= 1'b0;
         rd_data_r  <= 8'h00;
      end else begin
         state_r    <= state_nxt;
         addr_r     <= addr_nxt;
         cont_r     <= cont_nxt;
         rd_valid_r <= rd_valid_nxt;
         rd_data_r  <= rd_data_nxt;
      end
   end

   assign bank_bus.wr_en = wr_en;
   assign bank_bus.addr  = addr_r;
   assign bank_bus.wdata = host_byte;

   // ---------------------------------------------------------------
   // register bank
   // ---------------------------------------------------------------
   rcr_reg_bank u_bank (
      .clk                 (clk),
      .rst_n               (rst_n),
      .bus                 (bank_bus),
      .irq_status_in       (irq_status_in),
      .collision_in        (collision_in),
      .rssi_in             (rssi_in),
      .queue_status_in     (queue_status_in),
      .queue_data_in       (queue_data_in),
      .chip_status_control (csc),
      .protocol_select     (psel)
   );

   // ---------------------------------------------------------------
   // front-end control decode
   // ---------------------------------------------------------------
   logic [12:0] ctl_r;
   logic [12:0] ctl_nxt;

   // derive front-end controls from the status control byte, raw type from the protocol select byte; regulators and host clock tied on
   always_comb begin
      ctl_nxt[0]  = csc[rcr_pkg::BIT_STANDBY];
      ctl_nxt[1]  = 1'b1;
      ctl_nxt[2]  = 1'b1;
      ctl_nxt[3]  = csc[rcr_pkg::BIT_RAW_FRONTEND];
      ctl_nxt[4]  = psel[rcr_pkg::BIT_RAW_TYPE];
      ctl_nxt[5]  = !csc[rcr_pkg::BIT_RAW_FRONTEND];
      ctl_nxt[6]  = csc[rcr_pkg::BIT_TX_ENABLE];
      ctl_nxt[7]  = csc[rcr_pkg::BIT_TX_ENABLE]
                    | csc[rcr_pkg::BIT_FORCED_RX];
      ctl_nxt[8]  = csc[rcr_pkg::BIT_FORCED_RX]
                    | csc[rcr_pkg::BIT_TX_ENABLE];
      ctl_nxt[9]  = csc[rcr_pkg::BIT_POWER_SEL];
      ctl_nxt[10] = csc[rcr_pkg::BIT_RX_INPUT_SEL];
      ctl_nxt[11] = csc[rcr_pkg::BIT_AUTO_GAIN];
      ctl_nxt[12] = csc[rcr_pkg::BIT_SUPPLY_RANGE];
   end

   // control outputs registered, reset to 0x01 decode
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctl_r <= rcr_pkg::RST_CONTROL_OUTPUTS;
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign host_rd_valid          = rd_valid_r;
   assign host_rd_data           = rd_data_r;
   assign standby                = ctl_r[0];
   assign regulators_on          = ctl_r[1];
   assign host_clock_output_on   = ctl_r[2];
   assign raw_frontend           = ctl_r[3];
   assign raw_type               = ctl_r[4];
   assign framer_enable          = ctl_r[5];
   assign transmitter_on         = ctl_r[6];
   assign transmit_oscillator_on = ctl_r[7];
   assign receiver_on            = ctl_r[8];
   assign half_power             = ctl_r[9];
   assign auxiliary_input_sel    = ctl_r[10];
   assign auto_gain_on           = ctl_r[11];
   assign supply_5v              = ctl_r[12];

endmodule

// >>> verification/rcr_control_chk.sv
`timescale 1ns/100ps
// ---------------------------------------------
// port checker for the control register block
// ---------------------------------------------
module rcr_control_chk (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // host port
   input wire logic       host_valid,
   input wire logic       host_rd_valid,
   input wire logic [7:0] host_rd_data,
   // front-end controls
   input wire logic       standby,
   input wire logic       regulators_on,
   input wire logic       host_clock_output_on,
   input wire logic       raw_frontend,
   input wire logic       raw_type,
   input wire logic       framer_enable,
   input wire logic       transmitter_on,
   input wire logic       transmit_oscillator_on,
   input wire logic       receiver_on,
   input wire logic       half_power,
   input wire logic       auxiliary_input_sel,
   input wire logic       auto_gain_on,
   input wire logic       supply_5v
);
   // all controls except regulators_on and host_clock_output_on as one vector
   logic [10:0] ctl;
   assign ctl = {standby, raw_frontend, raw_type, framer_enable, transmitter_on,
                 transmit_oscillator_on, receiver_on, half_power, auxiliary_input_sel,
                 auto_gain_on, supply_5v};

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_reset_vals: assert property ($rose(rst_n) |-> supply_5v && framer_enable && !standby
      && !transmitter_on && !receiver_on && !raw_type) else $error("controls off after reset");
   chk_standby_supply: assert property (standby |-> regulators_on && host_clock_output_on)
      else $error("supply or clock dropped in standby");
   chk_framing_sel: assert property (framer_enable == !raw_frontend)
      else $error("framer enable disagrees with raw mode");
   chk_tx_receivers: assert property (transmitter_on |-> receiver_on)
      else $error("receiver off with transmitter on");
   chk_forced_pair: assert property (receiver_on == transmit_oscillator_on)
      else $error("receiver and oscillator disagree");
   chk_ctrl_cause: assert property ($changed(ctl) |-> $past(host_valid, 2)
      || !$past(rst_n, 2)) else $error("control changed without host write");
   chk_read_cause: assert property (host_rd_valid |-> $past(host_valid))
      else $error("read valid without data strobe");
   chk_read_hold: assert property ($past(rst_n) && !host_rd_valid |-> $stable(host_rd_data))
      else $error("read data moved outside a read");
endmodule

bind rcr_control rcr_control_chk chk_u (.clk, .rst_n, .host_valid, .host_rd_valid,
   .host_rd_data, .standby, .regulators_on, .host_clock_output_on, .raw_frontend, .raw_type,
   .framer_enable, .transmitter_on, .transmit_oscillator_on, .receiver_on, .half_power,
   .auxiliary_input_sel, .auto_gain_on, .supply_5v);

// >>> verification/rcr_host_model.sv
`timescale 1ns/100ps
// ---------------------------------------------
// host controller model, one byte per strobe
// ---------------------------------------------
module rcr_host_model (
   // clock
   input wire logic        clk,
   // host access port
   output logic            host_valid,
   output logic      [7:0] host_byte,
   output logic            host_frame_end,
   input  wire logic       host_rd_valid,
   input  wire logic [7:0] host_rd_data
);
   initial begin
      host_valid = 1'b0;
      host_byte = 8'h5a;
      host_frame_end = 1'b0;
   end

   // one byte strobe, launched just after an edge
   task automatic put(input logic [7:0] b);
      @(posedge clk);
      host_valid <= 1'b1;
      host_byte <= b;
   endtask

   // close the access; the released byte lane shows the inverse of its last value
   task automatic stop;
      @(posedge clk);
      host_valid <= 1'b0;
      host_frame_end <= 1'b1;
      host_byte <= ~host_byte;
      @(posedge clk);
      host_frame_end <= 1'b0;
   endtask

   // access words: bit 7 clear, bit 6 read, bit 5 continuous
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      put({3'b000, a});
      put(d);
      stop;
   endtask

   task automatic wr2(input logic [4:0] a, input logic [7:0] d0, input logic [7:0] d1);
      put({3'b001, a});
      put(d0);
      put(d1);
      stop;
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
      put({3'b010, a});
      put(8'h3c);
      @(posedge clk);
      host_valid <= 1'b0;
      host_frame_end <= 1'b1;
      @(posedge clk);
      ok = host_rd_valid;
      d = host_rd_data;
      host_frame_end <= 1'b0;
   endtask

   // continuous read of two neighbours, one answer per strobe
   task automatic rd2(input logic [4:0] a, output logic [7:0] d0, output logic [7:0] d1);
      put({3'b011, a});
      put(8'h3c);
      put(8'h3c);
      @(posedge clk);
      host_valid <= 1'b0;
      host_frame_end <= 1'b1;
      d0 = host_rd_data;
      @(posedge clk);
      d1 = host_rd_data;
      host_frame_end <= 1'b0;
   endtask
endmodule

// >>> verification/reader_control_register_map_tb_top.sv
`timescale 1ns/100ps
module reader_control_register_map_tb_top;
   logic       clk, rst_n, host_valid, host_frame_end, host_rd_valid;
   logic [7:0] host_byte, host_rd_data, irq_status_in, collision_in, rssi_in;
   logic [7:0] queue_status_in, queue_data_in;
   logic       standby, regulators_on, host_clock_output_on, raw_frontend, raw_type;
   logic       framer_enable, transmitter_on, transmit_oscillator_on, receiver_on;
   logic       half_power, auxiliary_input_sel, auto_gain_on, supply_5v;
   logic [12:0] outs;
   int         error_cnt = 0;
   int         compares = 0;

   rcr_control dut_u (.clk, .rst_n, .host_valid, .host_byte, .host_frame_end, .host_rd_valid,
      .host_rd_data, .irq_status_in, .collision_in, .rssi_in, .queue_status_in,
      .queue_data_in, .standby, .regulators_on, .host_clock_output_on, .raw_frontend,
      .raw_type, .framer_enable, .transmitter_on, .transmit_oscillator_on, .receiver_on,
      .half_power, .auxiliary_input_sel, .auto_gain_on, .supply_5v);
   rcr_host_model hm_u (.clk, .host_valid, .host_byte, .host_frame_end, .host_rd_valid,
      .host_rd_data);

   // controls packed in a fixed order for comparison
   assign outs = {regulators_on, host_clock_output_on, standby, raw_frontend, framer_enable,
                  transmitter_on, transmit_oscillator_on, receiver_on, half_power,
                  auxiliary_input_sel, auto_gain_on, supply_5v, raw_type};

   // supplies and host clock stay on in every mode
   function automatic logic [12:0] exp_outs(input logic [7:0] c, input logic rt);
      return {1'b1, 1'b1, c[7], c[6], !c[6], c[5], c[5] | c[1], c[5] | c[1], c[4], c[3], c[2],
              c[0], rt};
   endfunction

   task automatic check(input logic [12:0] got, input logic [12:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      logic       ok;
      hm_u.rd(a, d, ok);
      check({4'h0, ok, d}, {4'h0, 1'h1, exp}, what);
   endtask

   task automatic close_out;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic t_reset;
      rd_chk(5'h00, 8'h01, "status after reset");
      rd_chk(5'h01, 8'h02, "protocol after reset");
      check(outs, exp_outs(8'h01, 1'b0), "controls after reset");
      $display("test reset done");
   endtask

   // walk a single one through the status control register
   task automatic t_bits;
      logic [7:0] v;
      for (int i = 0; i < 8; i++) begin
         v = 8'h01 << i;
         hm_u.wr(5'h00, v);
         @(negedge clk);
         check(outs, exp_outs(v, 1'b0), "status bit");
         rd_chk(5'h00, v, "status readback");
      end
      $display("test bits done");
   endtask

   task automatic t_raw;
      hm_u.wr(5'h01, 8'h42);
      hm_u.wr(5'h00, 8'h40);
      @(negedge clk);
      check(outs, exp_outs(8'h40, 1'b1), "raw mode");
      $display("test raw done");
   endtask

   // read-only places, shared mask register, unmapped slot
   task automatic t_ro;
      logic [7:0] d0;
      logic [7:0] d1;
      hm_u.wr(5'h0f, 8'hc3);
      rd_chk(5'h0f, 8'h3c, "strength after write");
      @(posedge clk);
      rssi_in <= 8'h96;
      rd_chk(5'h0f, 8'h96, "strength live");
      hm_u.wr2(5'h0c, 8'h11, 8'h5a);
      rd_chk(5'h0d, 8'h5a, "mask register");
      hm_u.rd2(5'h0e, d0, d1);
      check({5'h00, d0}, {5'h00, 8'h21}, "collision live");
      check({5'h00, d1}, {5'h00, 8'h96}, "strength continuous");
      rd_chk(5'h0c, 8'ha5, "irq status");
      rd_chk(5'h1c, 8'h0e, "queue status");
      hm_u.wr(5'h04, 8'h77);
      rd_chk(5'h04, 8'h00, "unmapped");
      // a command word in idle must not open a write to the status register
      hm_u.put(8'h80);
      hm_u.put(8'h00);
      hm_u.stop;
      rd_chk(5'h00, 8'h40, "command word ignored");
      $display("test read-only done");
   endtask

   task automatic t_reset2;
      hm_u.wr(5'h00, 8'hfe);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(5'h00, 8'h01, "status after second reset");
      check(outs, exp_outs(8'h01, 1'b0), "controls after second reset");
      $display("test second reset done");
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      rst_n = 1'b0;
      irq_status_in = 8'ha5;
      collision_in = 8'h21;
      rssi_in = 8'h3c;
      queue_status_in = 8'h0e;
      queue_data_in = 8'h7b;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_bits;
      t_raw;
      t_ro;
      t_reset2;
      close_out;
   end

   // watchdog against a hung handshake
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      $display("wrong value at %0t: run timed out", $time);
      close_out;
   end
endmodule
